// ==== hdl/sdw_map.vh ====
// constants for the sdram write/refresh command core
// assumes inclusion by bare name from the core module
`ifndef SDW_MAP_VH
`define SDW_MAP_VH
// ************************************
// command codes as {ras_n, cas_n, we_n}
// ************************************
`define SDW_CMD_MRS 3'h0
`define SDW_CMD_REF 3'h1
`define SDW_CMD_PRE 3'h2
`define SDW_CMD_ACT 3'h3
`define SDW_CMD_WR 3'h4
`define SDW_CMD_RD 3'h5
// ************************************
// burst-length field codes and positions
// ************************************
`define SDW_BL_FIX8 2'h0
`define SDW_BL_OTF 2'h1
`define SDW_BL_FIX4 2'h2
`define SDW_BL_POS 0
`define SDW_ALLBANK_POS 10
`define SDW_BSEL_POS 12
`define SDW_LAST8 3'h7
`define SDW_LAST4 3'h3
// ************************************
// register offsets and reset values
// ************************************
`define SDW_REG_CTRL 4'h0
`define SDW_REG_STAT 4'h4
`define SDW_REG_VIOL 4'h8
`define SDW_CTRL_RST 2'h0
// ************************************
// timing
// ************************************
`define SDW_CLK_NS 10
`define SDW_RFC_NS 160
`define SDW_RFC_CYC ((`SDW_RFC_NS + `SDW_CLK_NS - 1) / `SDW_CLK_NS)
`endif

// ==== hdl/sdw_core.v ====
// sdram command core: column bursts, write masking, refresh lockout
// assumes command, address and data pins are already synchronous to clk
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sdw_map.vh"

// How it works
// - burst-select bit picks chop or eight beats
// - field 00 eight beats, 01 on-the-fly
// - field 10 fixed chopped four-beat bursts
// - strobe faults only counted, beat data still written
// - one write mask per eight data lines
// - write masks ignored during read bursts
// - refresh decoded per command, each issued anew
// - internal refresh row counter, banks left idle
module sdw_core #(
  parameter ADDR_W = 15,
  parameter BANK_W = 3,
  parameter DQ_W = 16,
  parameter COL_W = 4,
  parameter WL = 5,
  parameter RL = 6
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // command bus
  input wire cmd_cs_n,
  input wire cmd_ras_n,
  input wire cmd_cas_n,
  input wire cmd_we_n,
  input wire [BANK_W-1:0] cmd_ba,
  input wire [ADDR_W-1:0] cmd_addr,
  // write data path
  input wire [DQ_W-1:0] wdata,
  input wire [DQ_W/8-1:0] write_byte_mask,
  input wire strobe_ok,
  // read data path
  output wire [DQ_W-1:0] rdata,
  output reg rdata_valid,
  // status
  output wire refresh_busy,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);

  localparam LANES = DQ_W / 8;
  localparam BANKS = 1 << BANK_W;
  localparam MEM_AW = BANK_W + COL_W;
  localparam DEPTH = 1 << MEM_AW;
  // full-width forms first, then cut on purpose to the counter widths
  localparam [31:0] RFC_FULL = `SDW_RFC_CYC;
  localparam [31:0] WR_FULL = WL - 2;
  localparam [31:0] RD_FULL = RL - 3;
  localparam [7:0] RFC_CYC = RFC_FULL[7:0];
  localparam [4:0] WR_LOAD = WR_FULL[4:0];
  localparam [4:0] RD_LOAD = RD_FULL[4:0];
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_LAT = 3'h2;
  localparam [2:0] ST_BEAT = 3'h4;

  // ************************************
  // burst length decode
  // ************************************
  // eight beats unless the field or the select bit asks for a chop
  function is_eight;
    input [1:0] fld;
    input bsel;
    begin
      case (fld)
        `SDW_BL_FIX8: is_eight = 1'b1;
        `SDW_BL_OTF: is_eight = bsel;
        `SDW_BL_FIX4: is_eight = 1'b0;
        default: is_eight = 1'b1;
      endcase
    end
  endfunction

  reg [2:0] state_reg;
  reg [4:0] lat_reg;
  reg [2:0] beat_reg;
  reg [2:0] last_reg;
  reg dir_wr_reg;
  reg [MEM_AW-1:0] base_reg;
  reg [1:0] bl_field_reg;
  reg [7:0] rfc_cnt_reg;
  reg [15:0] ref_row_reg;
  reg [BANKS-1:0] bank_open_reg;
  reg [15:0] viol_reg;

  // ************************************
  // command decode
  // ************************************
  wire [2:0] cmd_code = {cmd_ras_n, cmd_cas_n, cmd_we_n};
  wire locked = (rfc_cnt_reg != 8'h00);
  // commands inside the refresh lockout are dropped, not queued
  wire cmd_ok = ~cmd_cs_n & ~locked;
  wire is_ref = cmd_ok & (cmd_code == `SDW_CMD_REF);
  wire is_mrs = cmd_ok & (cmd_code == `SDW_CMD_MRS);
  wire is_act = cmd_ok & (cmd_code == `SDW_CMD_ACT);
  wire is_pre = cmd_ok & (cmd_code == `SDW_CMD_PRE);
  wire is_wr = cmd_ok & (cmd_code == `SDW_CMD_WR);
  wire is_rd = cmd_ok & (cmd_code == `SDW_CMD_RD);
  wire col_go = (is_wr | is_rd) & (state_reg == ST_IDLE);
  wire sel_eight = is_eight(bl_field_reg, cmd_addr[`SDW_BSEL_POS]);
  wire in_beat = (state_reg == ST_BEAT);
  wire wr_beat = in_beat & dir_wr_reg;
  // reads never look at the mask pins
  wire rd_beat = in_beat & ~dir_wr_reg;
  wire viol_ev = wr_beat & ~strobe_ok;

  // ************************************
  // beat address generation
  // ************************************
  // sequential wrap inside the burst; select bit is not a column bit
  wire [2:0] off8 = base_reg[2:0] + beat_reg;
  wire [1:0] off4 = base_reg[1:0] + beat_reg[1:0];
  wire [2:0] off = (last_reg == `SDW_LAST8) ? off8 : {base_reg[2], off4};
  wire [MEM_AW-1:0] bt_addr = {base_reg[MEM_AW-1:3], off};

  // ************************************
  // burst sequencer
  // ************************************
  // one column burst at a time; a column command while busy is dropped
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      lat_reg <= 5'h00;
      beat_reg <= 3'h0;
      last_reg <= `SDW_LAST8;
      dir_wr_reg <= 1'b0;
      base_reg <= {MEM_AW{1'b0}};
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (col_go)
          begin
            dir_wr_reg <= is_wr;
            base_reg <= {cmd_ba, cmd_addr[COL_W-1:0]};
            last_reg <= sel_eight ? `SDW_LAST8 : `SDW_LAST4;
            lat_reg <= is_wr ? WR_LOAD : RD_LOAD;
            beat_reg <= 3'h0;
            state_reg <= ST_LAT;
          end
        end
        ST_LAT:
        begin
          if (lat_reg == 5'h00)
            state_reg <= ST_BEAT;
          else
            lat_reg <= lat_reg - 5'h01;
        end
        ST_BEAT:
        begin
          // burst always runs to its end, so a bad strobe cannot hang it
          beat_reg <= beat_reg + 3'h1;
          if (beat_reg == last_reg)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ************************************
  // storage, one array per byte lane
  // ************************************
  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1)
    begin : g_lane
      reg [7:0] mem [0:DEPTH-1];
      reg [7:0] q_reg;
      // a faulty strobe does not stop or spoil the write; it is only counted
      always @(posedge clk)
      begin
        if (wr_beat && !write_byte_mask[l])
          mem[bt_addr] <= wdata[l*8 +: 8];
      end
      always @(posedge clk)
      begin
        if (!rst_n)
          q_reg <= 8'h00;
        else if (rd_beat)
          q_reg <= mem[bt_addr];
      end
      assign rdata[l*8 +: 8] = q_reg;
    end
  endgenerate

  // read data qualifier lines up with the lane flops
  always @(posedge clk)
  begin
    if (!rst_n)
      rdata_valid <= 1'b0;
    else
      rdata_valid <= rd_beat;
  end

  // ************************************
  // refresh, bank state, mode field
  // ************************************
  // lockout counts the refresh cycle time; row comes from our counter
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rfc_cnt_reg <= 8'h00;
      ref_row_reg <= 16'h0000;
    end
    else if (is_ref)
    begin
      rfc_cnt_reg <= RFC_CYC - 8'h01;
      ref_row_reg <= ref_row_reg + 16'h0001;
    end
    else if (locked)
      rfc_cnt_reg <= rfc_cnt_reg - 8'h01;
  end

  // open-row tracking; refresh leaves every bank idle
  always @(posedge clk)
  begin
    if (!rst_n)
      bank_open_reg <= {BANKS{1'b0}};
    else if (is_ref)
      bank_open_reg <= {BANKS{1'b0}};
    else if (is_act)
      bank_open_reg[cmd_ba] <= 1'b1;
    else if (is_pre && cmd_addr[`SDW_ALLBANK_POS])
      bank_open_reg <= {BANKS{1'b0}};
    else if (is_pre)
      bank_open_reg[cmd_ba] <= 1'b0;
  end

  // mode field: command bus wins over the register port
  always @(posedge clk)
  begin
    if (!rst_n)
      bl_field_reg <= `SDW_CTRL_RST;
    else if (is_mrs && cmd_ba == {BANK_W{1'b0}})
      bl_field_reg <= cmd_addr[`SDW_BL_POS +: 2];
    else if (reg_wr && reg_addr == `SDW_REG_CTRL)
      bl_field_reg <= reg_wdata[`SDW_BL_POS +: 2];
  end

  // strobe fault counter; a fault in the clearing cycle still counts
  always @(posedge clk)
  begin
    if (!rst_n)
      viol_reg <= 16'h0000;
    else if (viol_ev)
      viol_reg <= (reg_wr && reg_addr == `SDW_REG_VIOL) ? 16'h0001 : viol_reg + 16'h0001;
    else if (reg_wr && reg_addr == `SDW_REG_VIOL)
      viol_reg <= 16'h0000;
  end

  assign refresh_busy = locked;

  // open-bank bits padded to one status byte; limits BANK_W to 3 or less
  reg [7:0] open_byte;
  always @*
  begin
    open_byte = 8'h00;
    open_byte[BANKS-1:0] = bank_open_reg;
  end

  // ************************************
  // register read port
  // ************************************
  // unmapped offsets read as zero; data stands one cycle after the strobe
  always @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SDW_REG_CTRL: reg_rdata <= {30'h00000000, bl_field_reg};
        `SDW_REG_STAT: reg_rdata <= {ref_row_reg, open_byte, 5'h00, dir_wr_reg, ~state_reg[0], locked};
        `SDW_REG_VIOL: reg_rdata <= {16'h0000, viol_reg};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end

endmodule // sdw_core
`default_nettype wire

// ==== sim/sdw_core_chk.sv ====
// assertions on the command core outputs
// assumes it is bound onto sdw_core, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sdw_core_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched pins
  input wire logic cmd_cs_n,
  input wire logic cmd_ras_n,
  input wire logic cmd_cas_n,
  input wire logic cmd_we_n,
  input wire logic rdata_valid,
  input wire logic refresh_busy,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // ****
  // taken commands
  // ****
  wire logic [2:0] code = {cmd_ras_n, cmd_cas_n, cmd_we_n};
  wire logic rd_cmd = !cmd_cs_n && code == 3'h5 && !refresh_busy;
  wire logic ref_cmd = !cmd_cs_n && code == 3'h1 && !refresh_busy;
  logic [3:0] since_reg;
  // saturates so that old reads age out
  always_ff @(posedge clk)
    if (!rst_n || rd_cmd)
      since_reg <= 4'h0;
    else if (since_reg != 4'hF)
      since_reg <= since_reg + 4'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ref_lock_a: assert property (ref_cmd |=> refresh_busy[*8] ##1 refresh_busy[*7] ##1 !refresh_busy)
    else $error("refresh lockout length wrong");
  lock_cause_a: assert property ($rose(refresh_busy) |-> $past(ref_cmd))
    else $error("lockout without refresh");
  rd_window_a: assert property (rdata_valid |-> since_reg inside {[5:12]})
    else $error("read beat outside burst window");
  rd_start_a: assert property ($rose(rdata_valid) |-> since_reg == 4'h5)
    else $error("read latency wrong");
  burst_len_a: assert property ($fell(rdata_valid) |-> $past(rdata_valid, 4) && (!$past(rdata_valid, 5) || $past(rdata_valid, 8)))
    else $error("burst neither four nor eight beats");
  min_beats_a: assert property ($rose(rdata_valid) |-> rdata_valid[*4])
    else $error("burst shorter than four beats");
  busy_quiet_a: assert property (refresh_busy |-> !$rose(rdata_valid))
    else $error("read data during refresh");
  reg_pulse_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("register data without read");
endmodule // sdw_core_chk
bind sdw_core sdw_core_chk u_sdw_core_chk (.clk, .rst_n, .cmd_cs_n, .cmd_ras_n, .cmd_cas_n, .cmd_we_n,
  .rdata_valid, .refresh_busy, .reg_rd, .reg_rdata);
`default_nettype wire

// ==== sim/sdw_ctl_model.sv ====
// memory controller model: one command per go, write beats at write latency
// assumes the bench spaces commands by at least 16 cycles
`timescale 1ns/1ps
`default_nettype none
module sdw_ctl_model #(
  parameter WL = 5
) (
  // bench side
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] op,
  input wire logic [2:0] ba,
  input wire logic [14:0] addr,
  input wire logic [15:0] base,
  input wire logic [1:0] mask,
  input wire logic [3:0] nb,
  // memory pins
  output logic cmd_cs_n,
  output logic cmd_ras_n,
  output logic cmd_cas_n,
  output logic cmd_we_n,
  output logic [2:0] cmd_ba,
  output logic [14:0] cmd_addr,
  output logic [15:0] wdata,
  output logic [1:0] write_byte_mask
);
  // ****
  // command and beat driver
  // ****
  int cnt = 99;
  logic wr_reg = 1'b0;
  initial
  begin
    {cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n} = 4'hF;
    {cmd_ba, cmd_addr, wdata, write_byte_mask} = '0;
  end
  // released lines toggle so stale values never look valid
  // wide spacing keeps every recovery and lockout time
  // refresh rate far inside the limits strobe from bench
  always @(posedge clk)
  begin
    cmd_cs_n <= !go;
    {cmd_ras_n, cmd_cas_n, cmd_we_n} <= go ? op : 3'h7;
    cmd_ba <= go ? ba : ~cmd_ba;
    cmd_addr <= go ? addr : ~cmd_addr;
    cnt <= go ? 1 : cnt + 1;
    if (go)
      wr_reg <= (op == 3'h4);
    if (wr_reg && cnt >= WL && cnt < WL + nb)
    begin
      wdata <= base + 16'(cnt - WL);
      write_byte_mask <= mask;
    end
    else
    begin
      wdata <= ~wdata;
      write_byte_mask <= ~write_byte_mask;
    end
  end
endmodule // sdw_ctl_model
`default_nettype wire

// ==== sim/sdw_core_tb_top.sv ====
// bench for sdw_core: bursts in every mode, masks, faults, refresh
// assumes the controller model and checker files compile first
`timescale 1ns/1ps
`default_nettype none
module sdw_core_tb_top;
  // ****
  // signals and instances
  // ****
  logic clk = 0, rst_n = 0, go = 0, strobe_ok = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] op = 3'h7, ba = 3'h0;
  logic [14:0] addr = 15'h0;
  logic [15:0] base = 16'h0, mem [0:63];
  logic [1:0] mask = 2'h0;
  logic [3:0] nb = 4'h8, reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, lfsr = 32'h42B5;
  wire logic cs_n, ras_n, cas_n, we_n, rdv, busy;
  wire logic [2:0] cba;
  wire logic [14:0] cad;
  wire logic [15:0] wd, rd;
  wire logic [1:0] wm;
  wire logic [31:0] rrd;
  int n_mismatch = 0, compares = 0;
  logic [15:0] got [$];
  sdw_ctl_model u_sdw_ctl_model (.clk, .go, .op, .ba, .addr, .base, .mask, .nb, .cmd_cs_n(cs_n),
    .cmd_ras_n(ras_n), .cmd_cas_n(cas_n), .cmd_we_n(we_n), .cmd_ba(cba), .cmd_addr(cad), .wdata(wd),
    .write_byte_mask(wm));
  sdw_core u_sdw_core (.clk, .rst_n, .cmd_cs_n(cs_n), .cmd_ras_n(ras_n), .cmd_cas_n(cas_n), .cmd_we_n(we_n),
    .cmd_ba(cba), .cmd_addr(cad), .wdata(wd), .write_byte_mask(wm), .strobe_ok, .rdata(rd), .rdata_valid(rdv),
    .refresh_busy(busy), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rrd));
  initial
    forever #5 clk = ~clk;
  // collect read beats away from the launching edge
  always @(negedge clk)
    if (rdv === 1'b1)
      got.push_back(rd);
  function automatic logic [31:0] step(input logic [31:0] s);
    step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // masked bytes keep what was stored
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] v, input logic [1:0] m);
    merge = {m[1] ? o[15:8] : v[15:8], m[0] ? o[7:0] : v[7:0]};
  endfunction
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(rrd, e);
  endtask
  // fixed 16-cycle spacing covers the longest burst and the lockout
  task automatic burst(input logic [2:0] o, input logic [2:0] b, input logic [14:0] a, input logic [3:0] n);
    @(posedge clk);
    op <= o;
    ba <= b;
    addr <= a;
    nb <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  // full write, masked write, then read back with mask lines toggling
  task automatic wr_rd(input logic [2:0] b, input logic a12, input logic [3:0] n, input logic bad);
    for (int w = 0; w < 2; w++)
    begin
      lfsr = step(lfsr);
      base <= lfsr[15:0];
      mask <= w ? lfsr[17:16] : 2'h0;
      strobe_ok <= !(bad && w);
      burst(3'h4, b, {2'h0, a12, 12'h0}, n);
      for (int i = 0; i < n; i++)
        mem[{b, i[2:0]}] = merge(mem[{b, i[2:0]}], lfsr[15:0] + 16'(i), w ? lfsr[17:16] : 2'h0);
    end
    strobe_ok <= 1'b1;
    reg_read(4'h8, bad ? {28'h0, n} : 32'h0);
    reg_write(4'h8, 32'h0);
    got.delete();
    burst(3'h5, b, {2'h0, a12, 12'h0}, n);
    check(got.size(), n);
    foreach (got[i]) check(got[i], mem[{b, i[2:0]}]);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(4'h0, 32'h0);
    reg_read(4'hC, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      lfsr = step(lfsr);
      if (k[0])
        reg_write(4'h0, 32'(k % 3));
      else
        burst(3'h0, 3'h0, 15'(k % 3), 4'h0);
      reg_read(4'h0, 32'(k % 3));
      wr_rd(lfsr[2:0], k > 2, (k % 3 == 2 || k == 1) ? 4'h4 : 4'h8, k == 1);
    end
    // spare field code falls back to eight beats
    reg_write(4'h0, 32'h3);
    reg_read(4'h0, 32'h3);
    wr_rd(3'h5, 1'b0, 4'h8, 1'b0);
    // open a bank, close it (single, then all-bank), then refresh
    for (int r = 1; r < 3; r++)
    begin
      lfsr = step(lfsr);
      burst(3'h3, lfsr[5:3], 15'h0000, 4'h0);
      reg_read(4'h4, {16'(r - 1), 8'(8'h01 << lfsr[5:3]), 8'h00});
      burst(3'h2, lfsr[5:3], (r == 2) ? 15'h0400 : 15'h0000, 4'h0);
      reg_read(4'h4, {16'(r - 1), 16'h0000});
      burst(3'h1, lfsr[2:0], lfsr[14:0], 4'h0);
      reg_read(4'h4, {16'(r), 16'h0});
    end
    close_out();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule // sdw_core_tb_top
`default_nettype wire
